// ==== pkg/btm_params.svh ====
// Constants of the transceiver mode register pair: map, fields, reset values.
// Assumes inclusion by bare name from the design files that need them.
`ifndef BTM_PARAMS_SVH
`define BTM_PARAMS_SVH
`define BTM_ADDR_CTRL_A   7'h04
`define BTM_ADDR_CTRL_B   7'h05
`define BTM_FRAME_BITS    5'd16
`define BTM_TX_LOAD_CNT   5'd8
`define BTM_CNT_MAX       5'd17
`define BTM_WR_BIT        7
`define BTM_A_FLASH       7
`define BTM_A_LSM         6
`define BTM_A_TXD_TO      5
`define BTM_B_PEAK        5
`define BTM_A_POR         8'h20
`define BTM_B_POR         8'h00
`define BTM_A_FAILSAFE    8'h09
`define BTM_B_FAILSAFE    8'h01
`define BTM_A_WR_MASK     8'hfb
`define BTM_B_WR_MASK     8'h03
`define BTM_B_PEAK_MASK   8'h20
`define BTM_A_HW_MASK     8'h1b
`define BTM_A_LOW_MASK    8'h1f
`define BTM_B_HW_MASK     8'h03
`define BTM_B_RESTART     8'hdf
`define BTM_A_RD_MASK     8'hfb
`define BTM_B_RD_MASK     8'h23
`endif

// ==== pkg/btm_pkg.sv ====
// Types shared by the transceiver mode register design.
// Assumes no other package; constants live in btm_params.svh.
package btm_pkg;

   // Two-bit transceiver mode encoding shared by CAN and both LINs.
   typedef enum logic [1:0] {
      BTM_XCVR_OFF    = 2'b00,
      BTM_XCVR_WAKE   = 2'b01,
      BTM_XCVR_RXONLY = 2'b10,
      BTM_XCVR_NORMAL = 2'b11
   } btm_xcvr_mode_t;

   // Operating mode of the surrounding system chip.
   typedef enum logic [1:0] {
      BTM_SBC_INIT   = 2'b00,
      BTM_SBC_NORMAL = 2'b01,
      BTM_SBC_STOP   = 2'b10,
      BTM_SBC_OTHER  = 2'b11
   } btm_sbc_mode_t;

   // Whole state of the register core.
   typedef struct packed {
      logic        cs_prev;
      logic        sclk_prev;
      logic [15:0] rx;
      logic [4:0]  bit_cnt;
      logic [7:0]  tx;
      logic        miso;
      logic        miso_oe;
      logic        err_seen;
      logic        frame_err;
      logic        cfg_commit;
      logic [7:0]  reg_a;
      logic [7:0]  reg_b;
   } btm_core_st_t;

   // Whole state of one transceiver mode decoder.
   typedef struct packed {
      logic tx_en;
      logic rx_en;
      logic wake_en;
   } btm_xcvr_st_t;

endpackage

// ==== rtl/btm_mode_regs.sv ====
// Transceiver mode register pair reached over the device serial port.
// Assumes a 200 MHz clk_sys that oversamples the serial pins, and mode and
// event inputs from the supervisor logic on the same clock.
`include "btm_params.svh"

module btm_mode_regs (
   input  wire logic                    clk_sys,
   input  wire logic                    arst_n,
   input  wire logic                    chip_select_n,
   input  wire logic                    spi_clk,
   input  wire logic                    spi_mosi,
   output logic                         spi_miso,
   output logic                         spi_miso_oe,
   input  wire btm_pkg::btm_sbc_mode_t  sbc_mode,
   input  wire logic                    evt_soft_reset,
   input  wire logic                    evt_restart,
   input  wire logic                    evt_failsafe,
   input  wire logic                    hw_mode_upd,
   input  wire btm_pkg::btm_xcvr_mode_t cause_can_mode,
   input  wire btm_pkg::btm_xcvr_mode_t cause_lin_a_mode,
   input  wire btm_pkg::btm_xcvr_mode_t cause_lin_b_mode,
   output logic                         lin_flash_bypass,
   output logic                         lin_low_slope_sel,
   output logic                         lin_tx_timeout_en,
   output btm_pkg::btm_xcvr_mode_t      can_mode,
   output btm_pkg::btm_xcvr_mode_t      lin_a_mode,
   output btm_pkg::btm_xcvr_mode_t      lin_b_mode,
   output logic                         supply_peak_threshold_sel,
   output logic                         can_tx_en,
   output logic                         can_rx_en,
   output logic                         can_wake_en,
   output logic                         lin_a_tx_en,
   output logic                         lin_a_rx_en,
   output logic                         lin_a_wake_en,
   output logic                         lin_b_tx_en,
   output logic                         lin_b_rx_en,
   output logic                         lin_b_wake_en,
   output logic                         spi_frame_err,
   output logic                         cfg_commit
);
   import btm_pkg::*;

   // Reset state of the whole core.
   localparam btm_core_st_t CORE_RST = '{
      cs_prev:    1'b1,
      sclk_prev:  1'b0,
      rx:         16'h0000,
      bit_cnt:    5'h00,
      tx:         8'h00,
      miso:       1'b0,
      miso_oe:    1'b0,
      err_seen:   1'b0,
      frame_err:  1'b0,
      cfg_commit: 1'b0,
      reg_a:      `BTM_A_POR,
      reg_b:      `BTM_B_POR
   };

   logic         rst_n;
   logic [2:0]   pin_s;
   logic         cs_s;
   logic         sclk_s;
   logic         mosi_s;
   logic         cs_fall;
   logic         cs_rise;
   logic         sclk_rise;
   logic         sclk_fall;
   logic [6:0]   frame_addr;
   logic         frame_wr;
   logic [7:0]   frame_data;
   logic         peak_wr_ok;
   logic [7:0]   status_byte;
   logic [7:0]   rd_byte;
   logic [7:0]   a_modes;
   logic [7:0]   b_modes;
   btm_core_st_t st_q;
   btm_core_st_t st_d;

   // Replaces the bits selected by mask and keeps all others.
   function automatic logic [7:0] merge_bits(input logic [7:0] old_v,
                                             input logic [7:0] new_v,
                                             input logic [7:0] mask);
      return (old_v & ~mask) | (new_v & mask);
   endfunction

   // Read value of a register; reserved bits and foreign addresses read zero.
   function automatic logic [7:0] read_reg(input logic [6:0] addr,
                                           input logic [7:0] a_v,
                                           input logic [7:0] b_v);
      logic [7:0] r;
      r = 8'h00;
      case (addr)
         `BTM_ADDR_CTRL_A: r = a_v & `BTM_A_RD_MASK;
         `BTM_ADDR_CTRL_B: r = b_v & `BTM_B_RD_MASK;
         default:          r = 8'h00;
      endcase
      return r;
   endfunction

   // Reset release passes two flops; assertion stays asynchronous.
   btm_sync #(
      .W       (1),
      .RST_VAL (1'b0)
   ) u_rst_sync (
      .clk_sys (clk_sys),
      .rst_n   (arst_n),
      .d       (1'b1),
      .q       (rst_n)
   );

   // Serial pins come from the host and are synchronised before use.
   btm_sync #(
      .W       (3),
      .RST_VAL (3'b100)
   ) u_pin_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       ({chip_select_n, spi_clk, spi_mosi}),
      .q       (pin_s)
   );

   assign cs_s   = pin_s[2];
   assign sclk_s = pin_s[1];
   assign mosi_s = pin_s[0];

   // Edges of the synchronised chip select and serial clock.
   assign cs_fall   = st_q.cs_prev & ~cs_s;
   assign cs_rise   = ~st_q.cs_prev & cs_s;
   assign sclk_rise = ~st_q.sclk_prev & sclk_s & ~cs_s;
   assign sclk_fall = st_q.sclk_prev & ~sclk_s & ~cs_s;

   // Fields of a received frame, least significant bit first on the wire.
   assign frame_addr = st_q.rx[6:0];
   assign frame_wr   = st_q.rx[`BTM_WR_BIT];
   assign frame_data = st_q.rx[15:8];

   // Serial writes change the peak threshold only in init and normal modes.
   assign peak_wr_ok = (sbc_mode == BTM_SBC_INIT) || (sbc_mode == BTM_SBC_NORMAL);

   // First byte out reports a frame error seen since the last frame.
   assign status_byte = {7'h00, st_q.err_seen};
   assign rd_byte     = read_reg(st_q.rx[14:8], st_q.reg_a, st_q.reg_b); // Address after 8 bits.

   // Cause-dependent mode values laid out at their register positions.
   assign a_modes = {3'b000, cause_lin_a_mode, 1'b0, cause_can_mode};
   assign b_modes = {6'h00, cause_lin_b_mode};

   // Serial shifting, frame commit and hardware updates of the registers.
   always_comb begin
      st_d            = st_q;
      st_d.cs_prev    = cs_s;
      st_d.sclk_prev  = sclk_s;
      st_d.frame_err  = 1'b0;
      st_d.cfg_commit = 1'b0;

      // Frame start clears the receiver and drives the status byte.
      if (cs_fall) begin
         st_d.rx       = 16'h0000;
         st_d.bit_cnt  = 5'h00;
         st_d.miso     = status_byte[0];
         st_d.tx       = {1'b0, status_byte[7:1]};
         st_d.miso_oe  = 1'b1;
         st_d.err_seen = 1'b0;
      end else if (!cs_s) begin
         // Data in is taken on the rising serial clock edge.
         if (sclk_rise) begin
            st_d.rx = {mosi_s, st_q.rx[15:1]};
            if (st_q.bit_cnt != `BTM_CNT_MAX) begin
               st_d.bit_cnt = st_q.bit_cnt + 5'd1;
            end
         end
         // Data out changes on the falling edge; the second byte holds
         // the register contents from before this frame's write.
         if (sclk_fall) begin
            if (st_q.bit_cnt == `BTM_TX_LOAD_CNT) begin
               st_d.miso = rd_byte[0];
               st_d.tx   = {1'b0, rd_byte[7:1]};
            end else begin
               st_d.miso = st_q.tx[0];
               st_d.tx   = {1'b0, st_q.tx[7:1]};
            end
         end
      end

      // Frame end releases the output and commits a complete write.
      if (cs_rise) begin
         st_d.miso_oe = 1'b0;
         st_d.miso    = 1'b0;
         if (st_q.bit_cnt == `BTM_FRAME_BITS) begin
            if (frame_wr && (frame_addr == `BTM_ADDR_CTRL_A)) begin
               // Flash, low-slope, time-out and mode fields take effect now.
               st_d.reg_a      = merge_bits(st_q.reg_a, frame_data,
                                            `BTM_A_WR_MASK);
               st_d.cfg_commit = 1'b1;
            end else if (frame_wr && (frame_addr == `BTM_ADDR_CTRL_B)) begin
               st_d.reg_b = merge_bits(st_q.reg_b, frame_data,
                                       `BTM_B_WR_MASK);
               // A blocked peak write is dropped silently with no error.
               if (peak_wr_ok) begin
                  st_d.reg_b = merge_bits(st_d.reg_b, frame_data,
                                          `BTM_B_PEAK_MASK);
               end
               st_d.cfg_commit = 1'b1;
            end
         end else begin
            st_d.frame_err = 1'b1;
            st_d.err_seen  = 1'b1;
         end
      end

      // Fail-safe, restart and soft reset override a same-cycle serial write; a mode update overrides only its mode fields.
      if (evt_failsafe) begin
         // Wake capable CAN and LINs so the device can be woken again.
         st_d.reg_a = merge_bits(st_q.reg_a, `BTM_A_FAILSAFE, `BTM_A_LOW_MASK);
         st_d.reg_b = `BTM_B_FAILSAFE;
      end else if (evt_restart) begin
         // Restart keeps the LIN options and the peak bit.
         st_d.reg_a = merge_bits(st_q.reg_a, a_modes, `BTM_A_LOW_MASK);
         st_d.reg_b = merge_bits(st_q.reg_b, b_modes, `BTM_B_RESTART);
      end else if (evt_soft_reset) begin
         st_d.reg_a = `BTM_A_POR;
         st_d.reg_b = `BTM_B_POR;
      end else if (hw_mode_upd) begin
         // Supervisor rewrites only the mode fields.
         st_d.reg_a = merge_bits(st_d.reg_a, a_modes, `BTM_A_HW_MASK);
         st_d.reg_b = merge_bits(st_d.reg_b, b_modes, `BTM_B_HW_MASK);
      end
   end

   // One register holds the whole core state.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= CORE_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // Serial output pin and frame pulses straight from the state.
   assign spi_miso      = st_q.miso;
   assign spi_miso_oe   = st_q.miso_oe;
   assign spi_frame_err = st_q.frame_err;
   assign cfg_commit    = st_q.cfg_commit;

   // Shared LIN options apply to both LIN transceivers.
   assign lin_flash_bypass  = st_q.reg_a[`BTM_A_FLASH];
   assign lin_low_slope_sel = st_q.reg_a[`BTM_A_LSM];
   assign lin_tx_timeout_en = st_q.reg_a[`BTM_A_TXD_TO];

   // Mode fields and the supply peak threshold select.
   assign lin_a_mode                = btm_xcvr_mode_t'(st_q.reg_a[4:3]);
   assign can_mode                  = btm_xcvr_mode_t'(st_q.reg_a[1:0]);
   assign lin_b_mode                = btm_xcvr_mode_t'(st_q.reg_b[1:0]);
   assign supply_peak_threshold_sel = st_q.reg_b[`BTM_B_PEAK];

   // Enables of the CAN transceiver.
   btm_xcvr_ctl u_can_ctl (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .mode    (btm_xcvr_mode_t'(st_q.reg_a[1:0])),
      .tx_en   (can_tx_en),
      .rx_en   (can_rx_en),
      .wake_en (can_wake_en)
   );

   // Enables of the first LIN transceiver.
   btm_xcvr_ctl u_lin_a_ctl (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .mode    (btm_xcvr_mode_t'(st_q.reg_a[4:3])),
      .tx_en   (lin_a_tx_en),
      .rx_en   (lin_a_rx_en),
      .wake_en (lin_a_wake_en)
   );

   // Enables of the second LIN transceiver.
   btm_xcvr_ctl u_lin_b_ctl (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .mode    (btm_xcvr_mode_t'(st_q.reg_b[1:0])),
      .tx_en   (lin_b_tx_en),
      .rx_en   (lin_b_rx_en),
      .wake_en (lin_b_wake_en)
   );

endmodule // btm_mode_regs

// ==== rtl/btm_sync.sv ====
// Two-flop synchroniser with a constant reset value.
// Assumes its input is asynchronous to clk_sys.
module btm_sync #(
   parameter int unsigned    W       = 1,
   parameter logic [W-1:0]   RST_VAL = '0
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } btm_sync_st_t;

   btm_sync_st_t st_q;
   btm_sync_st_t st_d;

   // The first stage is read only by the second stage.
   always_comb begin
      st_d    = st_q;
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
   end

   // Both stages take the constant reset value.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '{s1: RST_VAL, s2: RST_VAL};
      end else begin
         st_q <= st_d;
      end
   end

   assign q = st_q.s2;
endmodule // btm_sync

// ==== rtl/btm_xcvr_ctl.sv ====
// Decodes one transceiver mode field into registered enables.
// Assumes the mode comes from a register on the same clock.
module btm_xcvr_ctl (
   input  wire logic                    clk_sys,
   input  wire logic                    rst_n,
   input  wire btm_pkg::btm_xcvr_mode_t mode,
   output logic                         tx_en,
   output logic                         rx_en,
   output logic                         wake_en
);
   import btm_pkg::*;

   btm_xcvr_st_t st_q;
   btm_xcvr_st_t st_d;

   // Off drives nothing, receive-only listens, normal also transmits.
   always_comb begin
      st_d = st_q;
      case (mode)
         BTM_XCVR_OFF:    st_d = '{tx_en: 1'b0, rx_en: 1'b0, wake_en: 1'b0};
         BTM_XCVR_WAKE:   st_d = '{tx_en: 1'b0, rx_en: 1'b0, wake_en: 1'b1};
         BTM_XCVR_RXONLY: st_d = '{tx_en: 1'b0, rx_en: 1'b1, wake_en: 1'b0};
         BTM_XCVR_NORMAL: st_d = '{tx_en: 1'b1, rx_en: 1'b1, wake_en: 1'b0};
         default:         st_d = '{tx_en: 1'b0, rx_en: 1'b0, wake_en: 1'b0};
      endcase
   end

   // Enables start cleared so no transceiver is active out of reset.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '{tx_en: 1'b0, rx_en: 1'b0, wake_en: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign tx_en   = st_q.tx_en;
   assign rx_en   = st_q.rx_en;
   assign wake_en = st_q.wake_en;
endmodule // btm_xcvr_ctl

// ==== testbench/btm_mode_regs_chk.sv ====
// Concurrent checks on the ports of the transceiver mode register pair.
// Assumes one clock, clk_sys, and the pin reset arst_n for every check.
module btm_mode_regs_chk import btm_pkg::*; (
   input wire logic                    clk_sys,
   input wire logic                    arst_n,
   input wire logic                    chip_select_n,
   input wire btm_pkg::btm_sbc_mode_t  sbc_mode,
   input wire logic                    evt_soft_reset,
   input wire logic                    evt_restart,
   input wire logic                    evt_failsafe,
   input wire logic                    hw_mode_upd,
   input wire btm_pkg::btm_xcvr_mode_t cause_can_mode,
   input wire btm_pkg::btm_xcvr_mode_t cause_lin_a_mode,
   input wire btm_pkg::btm_xcvr_mode_t cause_lin_b_mode,
   input wire logic                    lin_flash_bypass,
   input wire logic                    lin_low_slope_sel,
   input wire logic                    lin_tx_timeout_en,
   input wire btm_pkg::btm_xcvr_mode_t can_mode,
   input wire btm_pkg::btm_xcvr_mode_t lin_a_mode,
   input wire btm_pkg::btm_xcvr_mode_t lin_b_mode,
   input wire logic                    supply_peak_threshold_sel,
   input wire logic                    can_rx_en,
   input wire logic                    can_wake_en,
   input wire logic                    lin_a_tx_en,
   input wire logic                    lin_b_rx_en,
   input wire logic                    spi_miso_oe,
   input wire logic                    cfg_commit
);
   timeunit 1ns;
   timeprecision 1ps;
   // Every check runs on the system clock and rests while reset is low.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   // A restart pulse that no fail-safe overrides, then the cause values in place.
   sequence restart_seen;
      evt_restart && !evt_failsafe;
   endsequence
   sequence restart_done;
      supply_peak_threshold_sel == $past(supply_peak_threshold_sel) &&
      can_mode == $past(cause_can_mode) && lin_a_mode == $past(cause_lin_a_mode) &&
      lin_b_mode == $past(cause_lin_b_mode);
   endsequence

   failsafe_load_a: assert property (evt_failsafe |=> can_mode == BTM_XCVR_WAKE &&
      lin_a_mode == BTM_XCVR_WAKE && lin_b_mode == BTM_XCVR_WAKE &&
      !supply_peak_threshold_sel && $stable(lin_flash_bypass))
      else $error("fail-safe load wrong");
   soft_reset_load_a: assert property (evt_soft_reset && !evt_failsafe && !evt_restart
      |=> lin_tx_timeout_en && !lin_flash_bypass && !lin_low_slope_sel &&
      can_mode == BTM_XCVR_OFF && lin_a_mode == BTM_XCVR_OFF && lin_b_mode == BTM_XCVR_OFF &&
      !supply_peak_threshold_sel) else $error("soft reset load wrong");
   restart_keep_a: assert property (restart_seen |=> restart_done)
      else $error("restart load wrong");
   hw_update_a: assert property (hw_mode_upd && !evt_failsafe && !evt_restart &&
      !evt_soft_reset |=> can_mode == $past(cause_can_mode) &&
      lin_a_mode == $past(cause_lin_a_mode) && lin_b_mode == $past(cause_lin_b_mode))
      else $error("hardware mode update wrong");
   peak_stop_hold_a: assert property (sbc_mode[1] && !evt_soft_reset && !evt_failsafe
      |=> $stable(supply_peak_threshold_sel)) else $error("peak bit changed in stop");
   lin_opt_change_a: assert property ($changed({lin_flash_bypass, lin_low_slope_sel,
      lin_tx_timeout_en}) |-> cfg_commit || $past(evt_soft_reset))
      else $error("LIN option changed without cause");
   can_wake_dec_a: assert property (can_wake_en == ($past(can_mode) == BTM_XCVR_WAKE))
      else $error("CAN wake enable wrong");
   can_rx_dec_a: assert property (can_rx_en == $past(can_mode[1]))
      else $error("CAN receive enable wrong");
   lin_a_tx_a: assert property (lin_a_tx_en == ($past(lin_a_mode) == BTM_XCVR_NORMAL))
      else $error("LIN A transmit enable wrong");
   lin_b_rx_a: assert property (lin_b_rx_en == $past(lin_b_mode[1]))
      else $error("LIN B receive enable wrong");
   miso_idle_off_a: assert property (chip_select_n [*5] |-> !spi_miso_oe)
      else $error("serial output driven while idle");
endmodule // btm_mode_regs_chk

bind btm_mode_regs btm_mode_regs_chk btm_mode_regs_chk_i (.clk_sys, .arst_n, .chip_select_n,
   .sbc_mode, .evt_soft_reset, .evt_restart, .evt_failsafe, .hw_mode_upd, .cause_can_mode,
   .cause_lin_a_mode, .cause_lin_b_mode, .lin_flash_bypass, .lin_low_slope_sel,
   .lin_tx_timeout_en, .can_mode, .lin_a_mode, .lin_b_mode, .supply_peak_threshold_sel,
   .can_rx_en, .can_wake_en, .lin_a_tx_en, .lin_b_rx_en, .spi_miso_oe, .cfg_commit);

// ==== testbench/btm_mode_regs_tb_top.sv ====
// Self-checking bench for the transceiver mode register pair.
// Assumes the host model and the bound checker; all frames are 16 bits unless refused.
`include "btm_params.svh"
module btm_mode_regs_tb_top import btm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, arst_n = 1'b0, go = 1'b0, done, cs_n, sclk, mosi, miso;
   logic [3:0] evt = 4'h0;
   logic hw_upd = 1'b0, fbyp, lsm, tto, peak, ctx, crx, cwk, atx, arx, awk, btx, brx, bwk, ferr;
   logic [4:0] nbits = 5'd16;
   logic [15:0] word = 16'h0000, rx;
   logic [7:0] d, st, ea, ferr_n = 8'h00;
   btm_sbc_mode_t sbc = BTM_SBC_INIT;
   btm_xcvr_mode_t cc = BTM_XCVR_OFF, ca = BTM_XCVR_OFF, cb = BTM_XCVR_OFF, cm, am, bm;
   int num_errors = 0, num_checks = 0;

   btm_spi_host btm_spi_host_i (.clk_sys(clk_sys), .go(go), .nbits(nbits), .word(word),
      .spi_miso(miso), .chip_select_n(cs_n), .spi_clk(sclk), .spi_mosi(mosi), .done(done),
      .rx(rx));
   btm_mode_regs btm_mode_regs_i (.clk_sys(clk_sys), .arst_n(arst_n), .chip_select_n(cs_n),
      .spi_clk(sclk), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(), .sbc_mode(sbc),
      .evt_soft_reset(evt[2]), .evt_restart(evt[1]), .evt_failsafe(evt[0]),
      .hw_mode_upd(hw_upd), .cause_can_mode(cc), .cause_lin_a_mode(ca), .cause_lin_b_mode(cb),
      .lin_flash_bypass(fbyp), .lin_low_slope_sel(lsm), .lin_tx_timeout_en(tto),
      .can_mode(cm), .lin_a_mode(am), .lin_b_mode(bm), .supply_peak_threshold_sel(peak),
      .can_tx_en(ctx), .can_rx_en(crx), .can_wake_en(cwk), .lin_a_tx_en(atx),
      .lin_a_rx_en(arx), .lin_a_wake_en(awk), .lin_b_tx_en(btx), .lin_b_rx_en(brx),
      .lin_b_wake_en(bwk), .spi_frame_err(ferr), .cfg_commit());

   // Free-running 200 MHz system clock.
   always #2.5 clk_sys = ~clk_sys;

   // Counts frame error pulses so refused frames can be checked.
   always @(posedge clk_sys) if (ferr === 1'b1) ferr_n <= ferr_n + 8'h01;

   // Compares one value with its expectation and counts the outcome.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Sends one frame through the host model and waits for it to finish.
   task automatic xfer(input logic [4:0] n, input logic [15:0] w);
      nbits <= n;
      word <= w;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      while (done !== 1'b1) @(posedge clk_sys);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      xfer(5'd16, {v, 1'b1, a});
   endtask

   task automatic rd(input logic [6:0] a);
      xfer(5'd16, {8'h00, 1'b0, a});
      d = rx[15:8];
      st = rx[7:0];
   endtask

   // Pulses the chosen event inputs for one clock, then lets the result settle.
   task automatic pulse(input logic [3:0] p);
      evt <= {1'b0, p[2:0]};
      hw_upd <= p[3];
      @(posedge clk_sys);
      evt <= 4'h0;
      hw_upd <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Cuts a hung run short.
   initial begin
      repeat (40000) @(posedge clk_sys);
      num_errors++;
      end_of_test();
   end

   // Main sequence of tests.
   initial begin
      repeat (12) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rd(`BTM_ADDR_CTRL_A);
      check(d, 8'h20);
      rd(`BTM_ADDR_CTRL_B);
      check(d, 8'h00);
      check({7'h00, tto}, 8'h01);
      $display("reset values done");
      for (int i = 0; i < 4; i++) begin
         ea = {i[0], i[1], ~i[0], i[1:0], 1'b0, i[1:0]};
         wr(`BTM_ADDR_CTRL_A, ea | 8'h04);
         wr(`BTM_ADDR_CTRL_B, {6'b111111, i[1:0]});
         rd(`BTM_ADDR_CTRL_A);
         check(d, ea);
         rd(`BTM_ADDR_CTRL_B);
         check(d, {6'b001000, i[1:0]});
         check({2'b00, cm, am, bm}, {2'b00, {3{i[1:0]}}});
         check({5'h00, fbyp, lsm, tto}, {5'h00, ea[7:5]});
         check({5'h00, cwk, awk, bwk}, {5'h00, {3{i == 1}}});
         check({2'b00, ctx, crx, atx, arx, btx, brx}, {2'b00, {3{i == 3, i[1]}}});
      end
      $display("mode fields done");
      wr(7'h06, 8'hff);
      rd(7'h06);
      check(d, 8'h00);
      sbc <= BTM_SBC_STOP;
      wr(`BTM_ADDR_CTRL_B, 8'h02);
      rd(`BTM_ADDR_CTRL_B);
      check(d, 8'h22);
      check(st, 8'h00);
      sbc <= BTM_SBC_NORMAL;
      wr(`BTM_ADDR_CTRL_B, 8'h01);
      rd(`BTM_ADDR_CTRL_B);
      check(d, 8'h01);
      $display("peak threshold done");
      check(ferr_n, 8'h00);
      xfer(5'd12, {8'h00, 1'b1, `BTM_ADDR_CTRL_A});
      rd(`BTM_ADDR_CTRL_A);
      check(d, 8'hdb);
      check(st, 8'h01);
      check(ferr_n, 8'h01);
      rd(`BTM_ADDR_CTRL_A);
      check(st, 8'h00);
      $display("short frame done");
      cc <= BTM_XCVR_RXONLY;
      ca <= BTM_XCVR_WAKE;
      cb <= BTM_XCVR_NORMAL;
      pulse(4'h8);
      check({2'b00, cm, am, bm}, 8'h27);
      wr(`BTM_ADDR_CTRL_B, 8'h21);
      cc <= BTM_XCVR_WAKE;
      ca <= BTM_XCVR_NORMAL;
      cb <= BTM_XCVR_RXONLY;
      pulse(4'h2);
      rd(`BTM_ADDR_CTRL_A);
      check(d, 8'hd9);
      rd(`BTM_ADDR_CTRL_B);
      check(d, 8'h22);
      pulse(4'h1);
      rd(`BTM_ADDR_CTRL_A);
      check(d, 8'hc9);
      rd(`BTM_ADDR_CTRL_B);
      check(d, 8'h01);
      pulse(4'h4);
      rd(`BTM_ADDR_CTRL_A);
      check(d, 8'h20);
      rd(`BTM_ADDR_CTRL_B);
      check(d, 8'h00);
      $display("hardware events done");
      end_of_test();
   end
endmodule // btm_mode_regs_tb_top

// ==== testbench/btm_spi_host.sv ====
// Host serial master model: sends one frame of nbits, LSB first, on a go pulse.
// Assumes clk_sys; each serial clock phase lasts six system clocks.
module btm_spi_host (
   input  wire logic        clk_sys,
   input  wire logic        go,
   input  wire logic [4:0]  nbits,
   input  wire logic [15:0] word,
   input  wire logic        spi_miso,
   output logic             chip_select_n,
   output logic             spi_clk,
   output logic             spi_mosi,
   output logic             done,
   output logic [15:0]      rx
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      chip_select_n = 1'b1;
      spi_clk = 1'b0;
      spi_mosi = 1'b0;
      done = 1'b0;
      rx = 16'h0000;
   end
   // Frame engine; the serial clock stands low outside frames and data is
   // inverted once released, so a stale bit can never look valid.
   always begin
      @(posedge clk_sys);
      if (go) begin
         chip_select_n <= 1'b0;
         repeat (6) @(posedge clk_sys);
         for (int i = 0; i < nbits; i++) begin
            spi_mosi <= word[i];
            repeat (6) @(posedge clk_sys);
            rx[i] <= spi_miso;
            spi_clk <= 1'b1;
            repeat (6) @(posedge clk_sys);
            spi_clk <= 1'b0;
         end
         repeat (6) @(posedge clk_sys);
         chip_select_n <= 1'b1;
         spi_mosi <= ~spi_mosi;
         repeat (8) @(posedge clk_sys);
         done <= 1'b1;
         @(posedge clk_sys);
         done <= 1'b0;
      end
   end
endmodule // btm_spi_host
